// [design/clk_ctrl_pkg.sv]
// Package of offsets, field layouts, reset values and timing constants
package clk_ctrl_pkg;
    localparam logic [11:0] OFS_IRQ_SET      = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR      = 12'h308;
    localparam logic [11:0] OFS_FAST_RUN     = 12'h408;
    localparam logic [11:0] OFS_FAST_STATE   = 12'h40c;
    localparam logic [11:0] OFS_SLOW_RUN     = 12'h414;
    localparam logic [11:0] OFS_SLOW_STATE   = 12'h418;
    localparam logic [11:0] OFS_SNAPSHOT     = 12'h41c;
    localparam logic [11:0] OFS_SRC_SELECT   = 12'h518;
    localparam logic [11:0] OFS_FAST_DEBOUNCE = 12'h528;
    localparam logic [11:0] OFS_SLOW_DEBOUNCE = 12'h52c;
    // Own registers: task triggers, event status, event clear, event inject
    localparam logic [11:0] OFS_TASKS        = 12'h600;
    localparam logic [11:0] OFS_EVT_STATUS   = 12'h604;
    localparam logic [11:0] OFS_EVT_CLEAR    = 12'h608;
    localparam logic [11:0] OFS_EVT_INJECT   = 12'h60c;

    localparam int N_EVT = 6;
    localparam int EVT_FAST_UP   = 0;
    localparam int EVT_SLOW_UP   = 1;
    localparam int EVT_CAL_DONE  = 2;
    localparam int EVT_CT_TO     = 3;
    localparam int EVT_CT_START  = 4;
    localparam int EVT_CT_STOP   = 5;

    localparam int TASK_FAST_START = 0;
    localparam int TASK_SLOW_START = 1;

    localparam int SEL_BYPASS_BIT   = 16;
    localparam int SEL_EXTERNAL_BIT = 17;

    localparam logic [1:0] SRC_RC    = 2'h0;
    localparam logic [1:0] SRC_XTAL  = 2'h1;
    localparam logic [1:0] SRC_SYNTH = 2'h2;

    localparam logic [N_EVT-1:0] IRQ_EN_RESET   = 6'h00;
    localparam logic [17:0]      SRC_SEL_RESET  = 18'h00000;
    localparam logic [1:0]       SNAPSHOT_RESET = 2'h0;
    localparam logic [7:0]       FAST_DEB_RESET = 8'h10;
    localparam logic [7:0]       SLOW_DEB_RESET = 8'h10;

    // Debounce unit is 16 us; power-up time of the fast crystal is assumed
    localparam int CLK_PERIOD_NS     = 100;
    localparam int DEB_UNIT_NS       = 16000;
    localparam int DEB_UNIT_CYC      = (DEB_UNIT_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    localparam int FAST_POWERUP_NS   = 100000;
    localparam int FAST_POWERUP_CYC  = (FAST_POWERUP_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
endpackage

// [design/osc_start_if.sv]
// Interface between the register file and one oscillator start timer
`timescale 1ns/1ns
interface osc_start_if;
    logic                                 start;
    logic [clk_ctrl_pkg::CNT_W-1:0]       cycles;
    logic                                 running;
    logic                                 up_event;
    modport ctrl  (output start, output cycles, input running, input up_event);
    modport timer (input start, input cycles, output running, output up_event);
endinterface

// [design/osc_start_timer.sv]
// Start timer: counts a settle time after a start and pulses an up event
`timescale 1ns/1ns
module osc_start_timer (
    input  wire logic   pclk,
    input  wire logic   presetn,
    osc_start_if.timer  tmr
);
    logic [clk_ctrl_pkg::CNT_W-1:0] count_q;
    logic                           busy_q;
    logic                           up_q;
    wire                            done = busy_q && (count_q <= 20'h00001);

    // A restart while busy reloads the count rather than stacking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
            busy_q  <= 1'b0;
            up_q    <= 1'b0;
        end else begin
            up_q <= done && !tmr.start;
            if (tmr.start) begin
                count_q <= tmr.cycles;
                busy_q  <= 1'b1;
            end else if (done) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                count_q <= count_q - 20'h00001;
            end
        end
    end

    assign tmr.running  = busy_q;
    assign tmr.up_event = up_q;
endmodule

// [design/clock_source_select_status.sv]
// Clock control register file: source select, run status, irq enables
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
module clock_source_select_status (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [1:0]  slow_source,
    output logic             slow_bypass,
    output logic             slow_external,
    output logic             irq
);
    osc_start_if fast_if ();
    osc_start_if slow_if ();

    logic [clk_ctrl_pkg::N_EVT-1:0] irq_en_q;
    logic [clk_ctrl_pkg::N_EVT-1:0] irq_en_d;
    logic [clk_ctrl_pkg::N_EVT-1:0] evt_q;
    logic [clk_ctrl_pkg::N_EVT-1:0] evt_d;
    logic [clk_ctrl_pkg::N_EVT-1:0] evt_hw;
    logic [1:0]                     src_q;
    logic                           bypass_q;
    logic                           external_q;
    logic [1:0]                     snap_q;
    logic                           fast_run_q;
    logic                           slow_run_q;
    logic [7:0]                     fast_deb_q;
    logic [7:0]                     slow_deb_q;
    logic [31:0]                    rdata_q;
    logic                           slow_src_q;

    // APB decode: zero wait states, access completes in its first cycle
    wire        acc        = psel && penable;
    wire        wr         = acc && pwrite;
    wire        rd         = acc && !pwrite;
    wire        hit_set    = paddr == clk_ctrl_pkg::OFS_IRQ_SET;
    wire        hit_clr    = paddr == clk_ctrl_pkg::OFS_IRQ_CLR;
    wire        hit_frun   = paddr == clk_ctrl_pkg::OFS_FAST_RUN;
    wire        hit_fstate = paddr == clk_ctrl_pkg::OFS_FAST_STATE;
    wire        hit_srun   = paddr == clk_ctrl_pkg::OFS_SLOW_RUN;
    wire        hit_sstate = paddr == clk_ctrl_pkg::OFS_SLOW_STATE;
    wire        hit_snap   = paddr == clk_ctrl_pkg::OFS_SNAPSHOT;
    wire        hit_src    = paddr == clk_ctrl_pkg::OFS_SRC_SELECT;
    wire        hit_fdeb   = paddr == clk_ctrl_pkg::OFS_FAST_DEBOUNCE;
    wire        hit_sdeb   = paddr == clk_ctrl_pkg::OFS_SLOW_DEBOUNCE;
    wire        hit_task   = paddr == clk_ctrl_pkg::OFS_TASKS;
    wire        hit_evt    = paddr == clk_ctrl_pkg::OFS_EVT_STATUS;
    wire        hit_eclr   = paddr == clk_ctrl_pkg::OFS_EVT_CLEAR;
    wire        hit_einj   = paddr == clk_ctrl_pkg::OFS_EVT_INJECT;
    wire        mapped     = hit_set | hit_clr | hit_frun | hit_fstate
                           | hit_srun | hit_sstate | hit_snap | hit_src
                           | hit_fdeb | hit_sdeb | hit_task | hit_evt
                           | hit_eclr | hit_einj;
    wire        aligned    = paddr[1:0] == 2'h0;
    wire        ok         = mapped && aligned;

    // Write masks per register; a one in a bit acts on that event only
    wire [5:0]  set_bits   = (wr && ok && hit_set)  ? pwdata[5:0] : 6'h00;
    wire [5:0]  clr_bits   = (wr && ok && hit_clr)  ? pwdata[5:0] : 6'h00;
    wire [5:0]  eclr_bits  = (wr && ok && hit_eclr) ? pwdata[5:0] : 6'h00;
    wire [5:0]  inj_bits   = (wr && ok && hit_einj) ? pwdata[5:0] : 6'h00;

    // Code 3 is not a source; it is kept out of the field
    wire [1:0]  src_next   = (pwdata[1:0] == 2'h3) ? src_q : pwdata[1:0];
    // Bypass and external bits of the select word
    wire        new_bypass = pwdata[clk_ctrl_pkg::SEL_BYPASS_BIT];
    wire        new_extern = pwdata[clk_ctrl_pkg::SEL_EXTERNAL_BIT];

    // Task strobes, one cycle each, from writes of one to the task register
    wire        fast_start = wr && ok && hit_task
                           && pwdata[clk_ctrl_pkg::TASK_FAST_START];
    wire        slow_start = wr && ok && hit_task
                           && pwdata[clk_ctrl_pkg::TASK_SLOW_START];

    // Only the crystal needs a debounce; RC and synth count one cycle
    wire        slow_xtal  = src_q == clk_ctrl_pkg::SRC_XTAL;
    wire [clk_ctrl_pkg::CNT_W-1:0] fast_cyc =
        20'(clk_ctrl_pkg::FAST_POWERUP_CYC
            + int'(fast_deb_q) * clk_ctrl_pkg::DEB_UNIT_CYC);
    wire [clk_ctrl_pkg::CNT_W-1:0] slow_cyc = slow_xtal ?
        20'(int'(slow_deb_q) * clk_ctrl_pkg::DEB_UNIT_CYC) : 20'h00001;

    assign fast_if.start  = fast_start;
    assign fast_if.cycles = fast_cyc;
    assign slow_if.start  = slow_start;
    assign slow_if.cycles = slow_cyc;

    osc_start_timer u_fast (
        .pclk    (pclk),
        .presetn (presetn),
        .tmr     (fast_if)
    );

    osc_start_timer u_slow (
        .pclk    (pclk),
        .presetn (presetn),
        .tmr     (slow_if)
    );

    // Hardware events; calibration events come only from the inject register
    // since the calibration logic lives outside this block
    assign evt_hw = {4'h0, slow_if.up_event, fast_if.up_event} | inj_bits;

    // Enable update: set register ORs ones in, disable register clears them
    assign irq_en_d = (irq_en_q | set_bits)
                    & ~clr_bits;

    // Sticky flags: a hardware set in the clearing cycle wins over the clear
    assign evt_d = (evt_q & ~eclr_bits) | evt_hw;

    assign irq = |(evt_q & irq_en_q);

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q   <= clk_ctrl_pkg::IRQ_EN_RESET;
            evt_q      <= 6'h00;
            src_q      <= clk_ctrl_pkg::SRC_SEL_RESET[1:0];
            bypass_q   <= 1'b0;
            external_q <= 1'b0;
            fast_deb_q <= clk_ctrl_pkg::FAST_DEB_RESET;
            slow_deb_q <= clk_ctrl_pkg::SLOW_DEB_RESET;
        end else begin
            irq_en_q <= irq_en_d;
            evt_q    <= evt_d;
            if (wr && ok && hit_src) begin
                src_q      <= src_next;
                bypass_q   <= new_bypass;
                external_q <= new_extern;
            end
            if (wr && ok && hit_fdeb) begin
                fast_deb_q <= pwdata[7:0];
            end
            if (wr && ok && hit_sdeb) begin
                slow_deb_q <= pwdata[7:0];
            end
        end
    end

    // Run status and snapshot taken at the slow start task
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_run_q <= 1'b0;
            slow_run_q <= 1'b0;
            snap_q     <= clk_ctrl_pkg::SNAPSHOT_RESET;
            slow_src_q <= 1'b0;
        end else begin
            if (fast_start) begin
                fast_run_q <= 1'b1;
            end
            if (slow_start) begin
                slow_run_q <= 1'b1;
                snap_q     <= src_q;
                slow_src_q <= 1'b1;
            end
        end
    end

    // Read mux; state registers show up in bit 16, fast running in bit 0, slow snapshot source in bits 1:0
    wire fast_up = fast_run_q && !fast_if.running;
    wire slow_up = slow_src_q && !slow_if.running;
    wire [31:0] rmux =
        (hit_set | hit_clr) ? {26'h0, irq_en_q} :
        hit_frun   ? {31'h0, fast_run_q} :
        hit_srun   ? {31'h0, slow_run_q} :
        hit_fstate ? {15'h0, fast_up, 15'h0, fast_if.running} :
        hit_sstate ? {15'h0, slow_up, 14'h0, snap_q} :
        hit_snap   ? {30'h0, snap_q} :
        hit_src    ? {14'h0, external_q, bypass_q, 14'h0, src_q} :
        hit_fdeb   ? {24'h0, fast_deb_q} :
        hit_sdeb   ? {24'h0, slow_deb_q} :
        hit_evt    ? {26'h0, evt_q} : 32'h0;

    // Read data registered in the setup cycle so it is stable in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            rdata_q <= ok ? rmux : 32'h0;
        end
    end

    assign prdata        = rdata_q;
    assign pready        = 1'b1;
    assign pslverr       = acc && !ok;
    assign slow_source   = src_q;
    assign slow_bypass   = bypass_q;
    assign slow_external = external_q;

    // Checks
    a_disable_clears: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && ok && hit_clr && pwdata[0] |=> !irq_en_q[0])
        else $error("enable bit survived a disable write");
    a_enable_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && ok && hit_set && pwdata[1] |=> irq_en_q[1])
        else $error("enable write did not set the bit");
    a_fast_run_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        fast_start |=> fast_run_q)
        else $error("fast run status not set by start");
    a_slow_run_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        slow_start |=> slow_run_q)
        else $error("slow run status not set by start");
    // Run status has no stop task here, so once set it must stay set
    a_fast_run_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        fast_run_q |=> fast_run_q)
        else $error("fast run status dropped");
    a_slow_run_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        slow_run_q |=> slow_run_q)
        else $error("slow run status dropped");
    a_snapshot_take: assert property (
        @(posedge pclk) disable iff (!presetn)
        slow_start |=> snap_q == $past(src_q))
        else $error("snapshot did not capture source");
    a_snapshot_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !slow_start |=> $stable(snap_q))
        else $error("snapshot changed without a start");
    a_source_legal: assert property (
        @(posedge pclk) disable iff (!presetn)
        src_q != 2'h3)
        else $error("source field holds an illegal code");
    a_bypass_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && ok && hit_src |=> slow_bypass == $past(new_bypass))
        else $error("bypass bit not written");
    a_slow_rc_fast: assert property (
        @(posedge pclk) disable iff (!presetn)
        slow_start && !slow_xtal |-> ##2 slow_if.up_event)
        else $error("slow up event late for non crystal source");
    a_fast_not_early: assert property (
        @(posedge pclk) disable iff (!presetn)
        fast_start |=> !fast_if.up_event [*8])
        else $error("fast up event came before settle time");
    // Enabling a flag that is already up must raise the interrupt
    a_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && ok && hit_set && |(pwdata[5:0] & evt_q) |=> irq)
        else $error("irq stayed low with an enabled flag");
    a_flag_sticks: assert property (
        @(posedge pclk) disable iff (!presetn)
        evt_hw[0] |=> evt_q[0])
        else $error("event flag lost against a clear");
endmodule

// [tb/clock_source_select_status_test.sv]
// Self-checking testbench for the clock control register file over APB
`timescale 1ns/1ns
module clock_source_select_status_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  slow_source;
    logic        slow_bypass;
    logic        slow_external;
    logic        irq;
    logic [31:0] rv;
    logic [31:0] d;
    logic        ev;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          t0;
    int          s;

    clock_source_select_status i_dut (
        .pclk          (pclk),
        .presetn       (presetn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .slow_source   (slow_source),
        .slow_bypass   (slow_bypass),
        .slow_external (slow_external),
        .irq           (irq)
    );

    // Clock and a free cycle count used to time the start events
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        ev = pslverr;
        t0 = cyc;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rv, exp);
    endtask

    // Polls the event flags; the watchdog bounds a flag that never rises
    task automatic wait_flag(input int b);
        apb(1'b0, clk_ctrl_pkg::OFS_EVT_STATUS, 32'h00000000);
        while (rv[b] !== 1'b1) apb(1'b0, clk_ctrl_pkg::OFS_EVT_STATUS, 32'h0);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        $display("watchdog expired at %0t", $time);
        results();
    end

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(clk_ctrl_pkg::OFS_SRC_SELECT, 32'h00000000);
        rd_chk(clk_ctrl_pkg::OFS_SNAPSHOT, 32'h00000000);
        rd_chk(clk_ctrl_pkg::OFS_IRQ_CLR, 32'h00000000);
        rd_chk(clk_ctrl_pkg::OFS_FAST_RUN, 32'h00000000);
        rd_chk(clk_ctrl_pkg::OFS_SLOW_RUN, 32'h00000000);
        $display("test reset_values done");
        // Clear one enable at a time so every bit position is exercised
        wr(clk_ctrl_pkg::OFS_IRQ_SET, 32'h0000003f);
        rd_chk(clk_ctrl_pkg::OFS_IRQ_CLR, 32'h0000003f);
        for (int i = 0; i < 6; i++) begin
            wr(clk_ctrl_pkg::OFS_IRQ_CLR, 32'h1 << i);
            d = 32'h3f & ~((32'h2 << i) - 32'h1);
            rd_chk(clk_ctrl_pkg::OFS_IRQ_CLR, d);
            rd_chk(clk_ctrl_pkg::OFS_IRQ_SET, d);
        end
        wr(clk_ctrl_pkg::OFS_IRQ_SET, 32'h0000003a);
        $display("test irq_enables done");
        // Injected flag with its enable off must not reach irq
        wr(clk_ctrl_pkg::OFS_EVT_INJECT, 32'h00000004);
        rd_chk(clk_ctrl_pkg::OFS_EVT_STATUS, 32'h00000004);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0);
        wr(clk_ctrl_pkg::OFS_IRQ_SET, 32'h00000004);
        @(negedge pclk);
        check({31'h0, irq}, 32'h1);
        wr(clk_ctrl_pkg::OFS_IRQ_CLR, 32'h00000004);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0);
        wr(clk_ctrl_pkg::OFS_EVT_CLEAR, 32'h00000004);
        rd_chk(clk_ctrl_pkg::OFS_EVT_STATUS, 32'h00000000);
        $display("test irq_output done");
        // Every source code, with bypass and external bits alongside
        for (int k = 0; k < 3; k++) begin
            d = 32'(k) | (32'(k == 1) << 17) | (32'(k != 0) << 16);
            wr(clk_ctrl_pkg::OFS_SRC_SELECT, d);
            rd_chk(clk_ctrl_pkg::OFS_SRC_SELECT, d);
            @(negedge pclk);
            check({29'h0, slow_external, slow_bypass, slow_source},
                  {29'h0, d[17:16], d[1:0]});
        end
        // Code 3 is refused: source stays synthesized
        wr(clk_ctrl_pkg::OFS_SRC_SELECT, 32'h00010003);
        rd_chk(clk_ctrl_pkg::OFS_SRC_SELECT, 32'h00010002);
        apb(1'b0, 12'h100, 32'h0);
        check(rv, 32'h0);
        check({31'h0, ev}, 32'h1);
        $display("test source_select done");
        // Fast start: power-up 1000 plus one debounce unit of 160 cycles
        wr(clk_ctrl_pkg::OFS_FAST_DEBOUNCE, 32'h00000001);
        wr(clk_ctrl_pkg::OFS_TASKS, 32'h00000001);
        s = t0;
        rd_chk(clk_ctrl_pkg::OFS_FAST_RUN, 32'h00000001);
        wait_flag(clk_ctrl_pkg::EVT_FAST_UP);
        check(32'((t0 - s) >= 1159 && (t0 - s) <= 1168), 32'h1);
        $display("test fast_start done");
        // Slow crystal start with external source; snapshot then holds
        wr(clk_ctrl_pkg::OFS_SLOW_DEBOUNCE, 32'h00000001);
        wr(clk_ctrl_pkg::OFS_SRC_SELECT, 32'h00020001);
        wr(clk_ctrl_pkg::OFS_TASKS, 32'h00000002);
        s = t0;
        rd_chk(clk_ctrl_pkg::OFS_SLOW_RUN, 32'h00000001);
        rd_chk(clk_ctrl_pkg::OFS_SNAPSHOT, 32'h00000001);
        wait_flag(clk_ctrl_pkg::EVT_SLOW_UP);
        check(32'((t0 - s) >= 159 && (t0 - s) <= 168), 32'h1);
        @(negedge pclk);
        check({31'h0, irq}, 32'h1);
        wr(clk_ctrl_pkg::OFS_SRC_SELECT, 32'h00000000);
        rd_chk(clk_ctrl_pkg::OFS_SNAPSHOT, 32'h00000001);
        wr(clk_ctrl_pkg::OFS_TASKS, 32'h00000002);
        rd_chk(clk_ctrl_pkg::OFS_SNAPSHOT, 32'h00000000);
        $display("test slow_start done");
        results();
    end
endmodule
